/* File: rtl/skew_regs_pkg.sv */
package skew_regs_pkg;

   // ==========================================================
   // bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned IDX_W  = 10;

   // ==========================================================
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_ALARM_STATUS   = 10'h2C1;
   localparam logic [IDX_W-1:0] IDX_LANE_FAULTS    = 10'h2C4;
   localparam logic [IDX_W-1:0] IDX_A_DUAL_TRIM    = 10'h310;
   localparam logic [IDX_W-1:0] IDX_B_DUAL_TRIM    = 10'h313;
   localparam logic [IDX_W-1:0] IDX_A_SINGLE_TRIM  = 10'h314;
   localparam logic [IDX_W-1:0] IDX_B_SINGLE_TRIM  = 10'h315;
   localparam logic [IDX_W-1:0] IDX_MODE_CTRL      = 10'h320;

   // ==========================================================
   // field layout
   localparam int unsigned LANES          = 16;
   localparam int unsigned TRIM_W         = 8;
   localparam int unsigned SUMMARY_BIT    = 5;
   localparam int unsigned MODE_SINGLE    = 0;
   localparam int unsigned MODE_FG_CAL    = 1;
   localparam int unsigned MODE_INPUT_B   = 2;
   localparam int unsigned MODE_W         = 3;

   // ==========================================================
   // values after reset
   localparam logic [LANES-1:0]  LANE_FAULTS_RST = 16'hFFFF;
   localparam logic              SUMMARY_RST     = 1'h1;
   localparam logic [TRIM_W-1:0] TRIM_RST        = 8'h00;
   localparam logic [MODE_W-1:0] MODE_RST        = 3'h0;

   // ==========================================================
   // bus handshake state
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_type;

endpackage

/* File: rtl/lane_fault_bank.sv */
`timescale 1ns/1ns

module lane_fault_bank
   import skew_regs_pkg::*;
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // lane events and clears
   input  wire logic [LANES-1:0] lane_fault,
   input  wire logic [LANES-1:0] clear_mask,
   // flags
   output logic      [LANES-1:0] flags_r
);

   // ==========================================================
   // one sticky flag per lane
   genvar i;
   generate
      for (i = 0; i < LANES; i++)
      begin : g_lane
         logic flag_nxt;

         // set outranks clear so an event in the clearing cycle survives
         assign flag_nxt = lane_fault[i]
                           | (flags_r[i] & ~clear_mask[i]);

         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
               flags_r[i] <= LANE_FAULTS_RST[i];
            else
               flags_r[i] <= flag_nxt;
         end
      end
   endgenerate

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_fault_sets_flag: assert property (
      (lane_fault != 16'h0000) |=> ((flags_r & $past(lane_fault)) == $past(lane_fault)))
      else $error("lane fault did not set its flag");
   a_clear_drops_flag: assert property (
      ((clear_mask & ~lane_fault) != 16'h0000)
      |=> ((flags_r & $past(clear_mask & ~lane_fault)) == 16'h0000))
      else $error("cleared lane flag stayed set");
   a_flag_stays_sticky: assert property (
      (clear_mask == 16'h0000) |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
      else $error("lane flag dropped without a clear");

endmodule

/* File: rtl/lane_alarm_and_timing_trim_regs.sv */
`timescale 1ns/1ns

module lane_alarm_and_timing_trim_regs
   import skew_regs_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [DATA_W-1:0] avs_writedata,
   output logic      [DATA_W-1:0] avs_readdata,
   output logic                   avs_waitrequest,
   // lane fifo events
   input  wire logic [LANES-1:0]  lane_fifo_fault,
   // fuse values
   input  wire logic [TRIM_W-1:0] fuse_a_dual_trim,
   input  wire logic [TRIM_W-1:0] fuse_b_dual_trim,
   input  wire logic [TRIM_W-1:0] fuse_a_single_trim,
   input  wire logic [TRIM_W-1:0] fuse_b_single_trim,
   // trims to the converter cores
   output logic      [TRIM_W-1:0] a_core_trim,
   output logic                   a_core_trim_valid,
   output logic      [TRIM_W-1:0] b_core_trim,
   output logic                   b_core_trim_valid
);

   // ==========================================================
   // state
   bus_state_type     bus_state_r;
   logic [DATA_W-1:0] readdata_r;
   logic [LANES-1:0]  lane_faults_r;
   logic [LANES-1:0]  lane_clear_nxt;
   logic              summary_r;
   logic [MODE_W-1:0] mode_r;
   logic              fuse_load_r;
   logic [TRIM_W-1:0] trims_r [4];
   logic [TRIM_W-1:0] a_trim_r;
   logic [TRIM_W-1:0] b_trim_r;
   logic              a_valid_r;
   logic              b_valid_r;
   logic [TRIM_W-1:0] fuse_vals [4];
   logic [IDX_W-1:0]  idx;
   logic              commit;
   logic              wr_commit;
   logic              summary_clear;
   logic [2:0]        slot;

   assign idx       = avs_address[ADDR_W-1:2];
   assign commit    = (avs_read | avs_write) & (bus_state_r == BUS_ACK);
   assign wr_commit = commit & avs_write;

   assign fuse_vals[0] = fuse_a_dual_trim;
   assign fuse_vals[1] = fuse_b_dual_trim;
   assign fuse_vals[2] = fuse_a_single_trim;
   assign fuse_vals[3] = fuse_b_single_trim;

   // ==========================================================
   // decoding shared by read and write paths
   function automatic logic [2:0] trim_slot(input logic [IDX_W-1:0] i);
      logic [2:0] s;
      s = 3'h4;
      case (i)
         IDX_A_DUAL_TRIM:   s = 3'h0;
         IDX_B_DUAL_TRIM:   s = 3'h1;
         IDX_A_SINGLE_TRIM: s = 3'h2;
         IDX_B_SINGLE_TRIM: s = 3'h3;
         default:           s = 3'h4;
      endcase
      return s;
   endfunction

   // one decode feeds the read mux; a function result cannot be sliced in place
   assign slot = trim_slot(idx);

   // ==========================================================
   // bus handshake: one wait cycle, then the answer
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         bus_state_r <= BUS_IDLE;
      else
      begin
         case (bus_state_r)
            BUS_IDLE: if (avs_read | avs_write) bus_state_r <= BUS_ACK;
            BUS_ACK:  bus_state_r <= BUS_IDLE;
            default:  bus_state_r <= BUS_IDLE;
         endcase
      end
   end

   // waitrequest low only in the acknowledge cycle
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         avs_waitrequest <= 1'h1;
      else
         avs_waitrequest <= ~((bus_state_r == BUS_IDLE) & (avs_read | avs_write));
   end

   // ==========================================================
   // read data, captured one cycle before the master samples it
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         readdata_r <= 32'h00000000;
      else if ((bus_state_r == BUS_IDLE) & avs_read)
      begin
         readdata_r <= 32'h00000000;
         if (slot != 3'h4)
            readdata_r[TRIM_W-1:0] <= trims_r[slot[1:0]];
         else if (idx == IDX_LANE_FAULTS)
            readdata_r[LANES-1:0] <= lane_faults_r;
         else if (idx == IDX_ALARM_STATUS)
            readdata_r[SUMMARY_BIT] <= summary_r;
         else if (idx == IDX_MODE_CTRL)
            readdata_r[MODE_W-1:0] <= mode_r;
      end
   end

   assign avs_readdata = readdata_r;

   // ==========================================================
   // lane fault flags and summary
   assign summary_clear = wr_commit & (idx == IDX_ALARM_STATUS) & avs_writedata[SUMMARY_BIT];

   always_comb
   begin
      lane_clear_nxt = 16'h0000;
      if (wr_commit & (idx == IDX_LANE_FAULTS))
         lane_clear_nxt = avs_writedata[LANES-1:0];
      if (summary_clear)
         lane_clear_nxt = 16'hFFFF;
   end

   lane_fault_bank u_lane_faults
   (
      .clk        (clk),
      .reset      (reset),
      .lane_fault (lane_fifo_fault),
      .clear_mask (lane_clear_nxt),
      .flags_r    (lane_faults_r)
   );

   // a fault in the clearing cycle keeps the summary set
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         summary_r <= SUMMARY_RST;
      else if (|lane_fifo_fault)
         summary_r <= 1'h1;
      else if (summary_clear)
         summary_r <= 1'h0;
   end

   // ==========================================================
   // mode control
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         mode_r <= MODE_RST;
      else if (wr_commit & (idx == IDX_MODE_CTRL))
         mode_r <= avs_writedata[MODE_W-1:0];
   end

   // ==========================================================
   // trim registers; fuses load at the first edge after reset release
   // because an asynchronous reset may only take constants
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         fuse_load_r <= 1'h1;
      else
         fuse_load_r <= 1'h0;
   end

   genvar t;
   generate
      for (t = 0; t < 4; t++)
      begin : g_trim
         always_ff @(posedge clk or posedge reset)
         begin
            if (reset)
               trims_r[t] <= TRIM_RST;
            else if (fuse_load_r)
               trims_r[t] <= fuse_vals[t];
            else if (wr_commit & (trim_slot(idx) == 3'(t)))
               trims_r[t] <= avs_writedata[TRIM_W-1:0];
         end
      end
   endgenerate

   // ==========================================================
   // pick the trim each core uses; input b settings are elsewhere
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         a_trim_r  <= TRIM_RST;
         a_valid_r <= 1'h0;
      end
      else if (!mode_r[MODE_SINGLE])
      begin
         a_trim_r  <= trims_r[0];
         a_valid_r <= 1'h1;
      end
      else if (mode_r[MODE_FG_CAL] & !mode_r[MODE_INPUT_B])
      begin
         a_trim_r  <= trims_r[2];
         a_valid_r <= 1'h1;
      end
      else
      begin
         a_trim_r  <= TRIM_RST;
         a_valid_r <= 1'h0;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         b_trim_r  <= TRIM_RST;
         b_valid_r <= 1'h0;
      end
      else if (!mode_r[MODE_SINGLE] & mode_r[MODE_FG_CAL])
      begin
         b_trim_r  <= trims_r[1];
         b_valid_r <= 1'h1;
      end
      else if (mode_r[MODE_SINGLE] & mode_r[MODE_FG_CAL] & !mode_r[MODE_INPUT_B])
      begin
         b_trim_r  <= trims_r[3];
         b_valid_r <= 1'h1;
      end
      else
      begin
         b_trim_r  <= TRIM_RST;
         b_valid_r <= 1'h0;
      end
   end

   assign a_core_trim       = a_trim_r;
   assign a_core_trim_valid = a_valid_r;
   assign b_core_trim       = b_trim_r;
   assign b_core_trim_valid = b_valid_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_summary_clears_all: assert property (
      summary_clear |=> ((lane_faults_r & ~$past(lane_fifo_fault)) == 16'h0000))
      else $error("summary clear left lane flags set");
   a_summary_on_fault: assert property (
      (|lane_fifo_fault) |=> summary_r)
      else $error("summary bit missed a lane fault");
   a_summary_w1c: assert property (
      (summary_clear & ~(|lane_fifo_fault)) |=> !summary_r)
      else $error("summary bit not cleared by write one");
   // the load edge is found by the fall, so the release edge itself is not judged
   a_fuse_loaded: assert property (
      $fell(fuse_load_r) |-> (trims_r[0] == $past(fuse_a_dual_trim)
                              && trims_r[3] == $past(fuse_b_single_trim)))
      else $error("fuse values not loaded after reset");
   a_trim_write: assert property (
      (wr_commit & (idx == IDX_B_DUAL_TRIM) & !fuse_load_r)
      |=> (trims_r[1] == $past(avs_writedata[TRIM_W-1:0])))
      else $error("trim write not stored");
   a_a_dual_select: assert property (
      (!mode_r[MODE_SINGLE] & !fuse_load_r)
      |=> (a_core_trim == $past(trims_r[0]) && a_core_trim_valid))
      else $error("a core dual trim not applied");
   a_b_dual_select: assert property (
      (!mode_r[MODE_SINGLE] & mode_r[MODE_FG_CAL])
      |=> (b_core_trim == $past(trims_r[1]) && b_core_trim_valid))
      else $error("b core dual trim not applied");
   a_a_single_select: assert property (
      (mode_r == 3'h3) |=> (a_core_trim == $past(trims_r[2]) && a_core_trim_valid))
      else $error("a core single trim not applied");
   a_b_single_select: assert property (
      (mode_r == 3'h3) |=> (b_core_trim == $past(trims_r[3]) && b_core_trim_valid))
      else $error("b core single trim not applied");
   a_bus_answers: assert property (
      ((avs_read | avs_write) & avs_waitrequest & (bus_state_r == BUS_IDLE))
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");
   a_lane_read_back: assert property (
      ((bus_state_r == BUS_IDLE) & avs_read & (idx == IDX_LANE_FAULTS))
      |=> (avs_readdata[LANES-1:0] == $past(lane_faults_r)))
      else $error("lane flags read back wrong");
   a_idle_waits: assert property (
      ((bus_state_r == BUS_IDLE) & !(avs_read | avs_write)) |=> avs_waitrequest)
      else $error("waitrequest low without a request");
   a_mode_write: assert property (
      (wr_commit & (idx == IDX_MODE_CTRL)) |=> (mode_r == $past(avs_writedata[MODE_W-1:0])))
      else $error("mode write not stored");

   c_lane_clear: cover property (
      wr_commit & (idx == IDX_LANE_FAULTS) & (avs_writedata[LANES-1:0] != 16'h0000));
   c_summary_clear: cover property (summary_clear);
   c_single_mode: cover property (mode_r == 3'h3);
   c_set_and_clear: cover property (summary_clear & (|lane_fifo_fault));
   c_fault_in_lane_clear: cover property (
      wr_commit & (idx == IDX_LANE_FAULTS) & (|(lane_fifo_fault & avs_writedata[LANES-1:0])));

endmodule

/* File: tb/lane_alarm_and_timing_trim_regs_test.sv */
`timescale 1ns/1ns

module lane_alarm_and_timing_trim_regs_test
   import skew_regs_pkg::*;
   ;

   // ==========================================================
   // signals
   logic              clk;
   logic              reset;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [DATA_W-1:0] avs_writedata;
   logic [DATA_W-1:0] avs_readdata;
   logic              avs_waitrequest;
   logic [LANES-1:0]  lane_fifo_fault;
   logic [TRIM_W-1:0] fuse_m [4];
   logic [TRIM_W-1:0] a_core_trim;
   logic              a_core_trim_valid;
   logic [TRIM_W-1:0] b_core_trim;
   logic              b_core_trim_valid;
   logic [TRIM_W-1:0] trim_m [4];
   logic [IDX_W-1:0]  trim_idx [4];
   logic [31:0]       lfsr_state;
   logic [31:0]       v;
   int                miscompares;
   int                checked;

   lane_alarm_and_timing_trim_regs lane_alarm_and_timing_trim_regs_i
   (
      .clk                (clk),
      .reset              (reset),
      .avs_address        (avs_address),
      .avs_read           (avs_read),
      .avs_write          (avs_write),
      .avs_writedata      (avs_writedata),
      .avs_readdata       (avs_readdata),
      .avs_waitrequest    (avs_waitrequest),
      .lane_fifo_fault    (lane_fifo_fault),
      .fuse_a_dual_trim   (fuse_m[0]),
      .fuse_b_dual_trim   (fuse_m[1]),
      .fuse_a_single_trim (fuse_m[2]),
      .fuse_b_single_trim (fuse_m[3]),
      .a_core_trim        (a_core_trim),
      .a_core_trim_valid  (a_core_trim_valid),
      .b_core_trim        (b_core_trim),
      .b_core_trim_valid  (b_core_trim_valid)
   );

   // ==========================================================
   // clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // the whole run is a few hundred cycles; a hang outside the bus task ends here
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      finish_test();
   end

   // ==========================================================
   // helpers
   function logic [31:0] rnd();
      lfsr_state = {lfsr_state[30:0],
                    lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
      return lfsr_state;
   endfunction

   // expected {valid, trim} of one core for a mode word
   function automatic logic [31:0] exp_core(input logic b, input logic [MODE_W-1:0] m);
      logic s;
      logic f;
      logic ib;
      s  = m[MODE_SINGLE];
      f  = m[MODE_FG_CAL];
      ib = m[MODE_INPUT_B];
      if (s && f && !ib)
         return {23'h0, 1'b1, trim_m[b ? 3 : 2]};
      if (!s && (!b || f))
         return {23'h0, 1'b1, trim_m[b ? 1 : 0]};
      return 32'h0;
   endfunction

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one avalon access; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                      output logic [31:0] rdat);
      int n;
      @(posedge clk);
      avs_address   <= {idx, 2'b00};
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= wd;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0)
      begin
         miscompares++;
         finish_test();
      end
      rdat = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
      logic [31:0] dummy;
      bus(1'b1, idx, d, dummy);
   endtask

   task automatic rc(input string what, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, idx, 32'h0, r);
      check(what, r, exp);
   endtask

   task automatic pulse(input logic [LANES-1:0] f);
      @(posedge clk);
      lane_fifo_fault <= f;
      @(posedge clk);
      lane_fifo_fault <= '0;
   endtask

   // outputs follow a mode or trim change one edge later
   task automatic core_check(input logic [MODE_W-1:0] m);
      logic [31:0] sa;
      logic [31:0] sb;
      repeat (3) @(posedge clk);
      sa = {23'h0, a_core_trim_valid, a_core_trim};
      sb = {23'h0, b_core_trim_valid, b_core_trim};
      check("a_core", sa, exp_core(1'b0, m));
      check("b_core", sb, exp_core(1'b1, m));
   endtask

   // fuses change only while reset is held, since they are sampled at release
   task automatic do_reset();
      int i;
      reset <= 1'b1;
      for (i = 0; i < 4; i++)
         fuse_m[i] <= 8'(rnd());
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      trim_m = fuse_m;
   endtask

   task automatic reset_values();
      int i;
      rc("lane_flags", IDX_LANE_FAULTS, 32'hFFFF);
      rc("alarm_status", IDX_ALARM_STATUS, 32'h20);
      for (i = 0; i < 4; i++)
         rc("trim_fuse", trim_idx[i], {24'h0, trim_m[i]});
      core_check('0);
      $display("test reset_values done");
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      int k;
      logic [15:0] m;
      reset           = 1'b1;
      avs_address     = '0;
      avs_read        = 1'b0;
      avs_write       = 1'b0;
      avs_writedata   = '0;
      lane_fifo_fault = '0;
      miscompares     = 0;
      checked         = 0;
      lfsr_state      = 32'h6C31;
      trim_idx = '{IDX_A_DUAL_TRIM, IDX_B_DUAL_TRIM, IDX_A_SINGLE_TRIM, IDX_B_SINGLE_TRIM};
      do_reset();
      reset_values();

      wr(IDX_LANE_FAULTS, 32'hFFFF);
      rc("lane_clear_all", IDX_LANE_FAULTS, 32'h0);
      for (k = 0; k < 6; k++)
      begin
         v = rnd();
         m = (k == 0) ? 16'h0 : v[15:0];
         pulse(16'hFFFF);
         wr(IDX_LANE_FAULTS, {16'h0, m});
         rc("lane_partial", IDX_LANE_FAULTS, {16'h0, ~m});
      end
      $display("test lane_w1c done");

      wr(IDX_LANE_FAULTS, 32'hFFFF);
      wr(IDX_ALARM_STATUS, 32'h20);
      v = rnd();
      m = 16'h1 << v[3:0];
      pulse(m);
      repeat (4) @(posedge clk);
      rc("lane_sticky", IDX_LANE_FAULTS, {16'h0, m});
      rc("summary_set", IDX_ALARM_STATUS, 32'h20);
      @(posedge clk);
      lane_fifo_fault <= 16'h8001;
      wr(IDX_LANE_FAULTS, 32'hFFFF);
      lane_fifo_fault <= '0;
      rc("lane_persist", IDX_LANE_FAULTS, 32'h8001);
      pulse(16'hFFFF);
      wr(IDX_ALARM_STATUS, 32'h20);
      rc("summary_clear_lanes", IDX_LANE_FAULTS, 32'h0);
      rc("summary_clear", IDX_ALARM_STATUS, 32'h0);
      pulse(16'hFFFF);
      m = 16'h1 << v[7:4];
      @(posedge clk);
      lane_fifo_fault <= m;
      wr(IDX_ALARM_STATUS, 32'h20);
      lane_fifo_fault <= '0;
      rc("summary_fault_lanes", IDX_LANE_FAULTS, {16'h0, m});
      rc("summary_held", IDX_ALARM_STATUS, 32'h20);
      $display("test lane_summary done");

      for (k = 0; k < 4; k++)
      begin
         v = rnd();
         wr(trim_idx[k], v);
         trim_m[k] = v[7:0];
         rc("trim_rw", trim_idx[k], {24'h0, v[7:0]});
      end
      for (k = 0; k < 8; k++)
      begin
         wr(IDX_MODE_CTRL, k);
         core_check(k[MODE_W-1:0]);
      end
      wr(10'h3FF, rnd());
      rc("unmapped", 10'h3FF, 32'h0);
      $display("test trims_modes done");

      do_reset();
      reset_values();
      finish_test();
   end

endmodule
